// *** src/fai_checker.sv ***
// Implementation choices: register access over APB and the register addresses.
`timescale 1ns/100ps
// Function
// - every address of the range is read and folded into the signature, none skipped, for any wait-state and pipeline setting.
// - with breakpoints on, an ecc or correction event halts the sweep and resume continues at the very next address.
// - two events on consecutive reads each raise their own breakpoint.
// - with breakpoints off, the first event is recorded and the sweep runs to the end.
// - margin reads use their own fixed timing, not the wait-state setting.
// - wait states and pipeline depth come from the config register and time the array reads.
module fai_checker
	import fai_pkg::*;
(
	input wire logic pclk,
	input wire logic presetn,
	input wire logic psel,
	input wire logic penable,
	input wire logic pwrite,
	input wire logic [11:0] paddr,
	input wire logic [31:0] pwdata,
	output logic [31:0] prdata,
	output logic pready,
	output logic pslverr,
	output fai_rd_t rd_o,
	input wire fai_rsp_t rsp_i,
	output logic irq
);
	typedef enum logic [1:0] {S_IDLE, S_RUN, S_BRK, S_DONE} fai_st_t;
	fai_st_t st_ff;
	logic [AW-1:0] start_ff, end_ff, addr_ff, eaddr_ff;
	logic [2:0] rws_ff;
	logic [1:0] apd_ff;
	logic brk_en_ff, margin_ff;
	logic [31:0] sig_ff;
	fai_ev_t ev_ff;
	logic ev_seen_ff;
	logic [3:0] wait_ff, since_ff;
	logic brk_last_ff;
	logic busy_ff;
	logic [2:0] irq_st_ff, irq_mask_ff;
	logic [31:0] prdata_ff;

	wire wr = psel & penable & pwrite;
	wire rd = psel & penable & ~pwrite;
	wire hit_ctrl = paddr == OFF_CTRL;
	wire hit_cfg = paddr == OFF_CFG;
	wire hit_start = paddr == OFF_START;
	wire hit_end = paddr == OFF_END;
	wire hit_stat = paddr == OFF_STAT;
	wire hit_sig = paddr == OFF_SIG;
	wire hit_eaddr = paddr == OFF_EADDR;
	wire hit_irq = paddr == OFF_IRQ;
	wire hit_mask = paddr == OFF_MASK;
	wire hit_id = paddr == OFF_ID;
	wire mapped = hit_ctrl | hit_cfg | hit_start | hit_end | hit_stat |
		hit_sig | hit_eaddr | hit_irq | hit_mask | hit_id;
	wire idle = (st_ff == S_IDLE) | (st_ff == S_DONE);
	wire go = wr & hit_ctrl & pwdata[0] & idle;
	wire resume = wr & hit_ctrl & pwdata[1] & (st_ff == S_BRK);
	// read latency: margin self-timed, array by wait states + 1
	wire [3:0] ws_lat = 4'({1'b0, rws_ff} + 4'h1);
	wire [3:0] lat = margin_ff ? MARGIN_CYC : ws_lat;
	wire [3:0] gap_cyc = margin_ff ? 4'h0 : {2'b00, apd_ff};
	wire [3:0] wait_dec = (wait_ff == 4'h0) ? 4'h0 : wait_ff - 4'h1;
	wire [3:0] nxt_wait = (wait_dec > gap_cyc) ? wait_dec : gap_cyc;
	wire issue = (st_ff == S_RUN) & ~busy_ff & (wait_ff == 4'h0);
	wire [3:0] nxt_since = issue ? 4'h1 :
		((since_ff == 4'hF) ? since_ff : since_ff + 4'h1);
	wire resp = rsp_i.valid & busy_ff;
	wire ev = resp & (rsp_i.ecc_err | rsp_i.single_bit_correction_event);
	wire last = addr_ff == end_ff;
	wire [31:0] sig_shift = {sig_ff[30:0], 1'b0} ^
		(sig_ff[31] ? SIG_POLY : 32'h00000000);
	wire [31:0] nxt_sig = sig_shift ^ rsp_i.data;
	wire fai_ev_t nxt_ev = rsp_i.ecc_err ? FAI_EV_ECC : FAI_EV_SBC;
	wire done_set = (resp & last & ~(ev & brk_en_ff)) |
		(resume & brk_last_ff);
	wire [2:0] irq_set = {ev, done_set, ev & brk_en_ff};
	// a read clears only the status bits it actually returned
	wire [2:0] irq_clr = (rd & hit_irq) ? prdata_ff[2:0] : 3'h0;
	assign irq = |(irq_st_ff & irq_mask_ff);
	assign pready = 1'b1;
	assign pslverr = psel & penable & ~mapped;
	assign prdata = prdata_ff;
	assign rd_o.req = issue;
	assign rd_o.margin = margin_ff;
	assign rd_o.addr = addr_ff;

	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			rws_ff <= RWS_RST;
			apd_ff <= APD_RST;
			brk_en_ff <= 1'b0;
			margin_ff <= 1'b0;
			start_ff <= '0;
			end_ff <= '0;
			irq_mask_ff <= 3'h0;
		end else if (wr) begin
			if (hit_cfg && idle) begin
				rws_ff <= pwdata[2:0];
				apd_ff <= pwdata[5:4];
				brk_en_ff <= pwdata[8];
				margin_ff <= pwdata[9];
			end
			if (hit_start) start_ff <= pwdata[AW-1:0];
			if (hit_end) end_ff <= pwdata[AW-1:0];
			if (hit_mask) irq_mask_ff <= pwdata[2:0];
		end
	end

	// one read outstanding; pipeline depth gaps issue after each answer, except in margin mode (no gap)
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			busy_ff <= 1'b0;
			wait_ff <= 4'h0;
		end else if (issue) begin
			busy_ff <= 1'b1;
			wait_ff <= lat;
		end else if (resp) begin
			busy_ff <= 1'b0;
			wait_ff <= nxt_wait;
		end else if (wait_ff != 4'h0) begin
			wait_ff <= wait_ff - 4'h1;
		end
	end

	// cycles since the last array read request, saturating
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn)
			since_ff <= 4'hF;
		else
			since_ff <= nxt_since;
	end

	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			st_ff <= S_IDLE;
			addr_ff <= '0;
			sig_ff <= SIG_SEED;
			brk_last_ff <= 1'b0;
		end else begin
			case (st_ff)
				S_IDLE, S_DONE: if (go) begin
					st_ff <= S_RUN;
					addr_ff <= start_ff;
					sig_ff <= SIG_SEED;
				end
				S_RUN: if (resp) begin
					sig_ff <= nxt_sig;
					brk_last_ff <= last;
					if (last)
						st_ff <= S_DONE;
					else
						addr_ff <= addr_ff + AW'(1);
					if (ev && brk_en_ff)
						st_ff <= S_BRK;
				end
				S_BRK: if (resume)
					st_ff <= brk_last_ff ? S_DONE : S_RUN;
				default: st_ff <= S_IDLE;
			endcase
		end
	end

	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			ev_ff <= FAI_EV_NONE;
			eaddr_ff <= '0;
			ev_seen_ff <= 1'b0;
		end else if (go) begin
			ev_ff <= FAI_EV_NONE;
			ev_seen_ff <= 1'b0;
		end else if (st_ff == S_RUN && ev && (brk_en_ff || !ev_seen_ff)) begin
			ev_ff <= nxt_ev;
			eaddr_ff <= addr_ff;
			ev_seen_ff <= 1'b1;
		end
	end

	// status sticky, cleared by a read; a new event wins over the clear
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn)
			irq_st_ff <= 3'h0;
		else
			irq_st_ff <= (irq_st_ff & ~irq_clr) | irq_set;
	end

	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn)
			prdata_ff <= 32'h00000000;
		else if (psel && !penable && !pwrite)
			prdata_ff <= hit_ctrl ? {30'h0, st_ff == S_BRK, st_ff == S_RUN} :
				hit_cfg ? {22'h0, margin_ff, brk_en_ff, 2'h0, apd_ff,
					1'b0, rws_ff} :
				hit_start ? 32'(start_ff) :
				hit_end ? 32'(end_ff) :
				hit_stat ? {26'h0, ev_ff, ev_seen_ff, st_ff == S_DONE,
					st_ff == S_BRK, st_ff == S_RUN} :
				hit_sig ? sig_ff :
				hit_eaddr ? 32'(eaddr_ff) :
				hit_irq ? {29'h0, irq_st_ff} :
				hit_mask ? {29'h0, irq_mask_ff} :
				hit_id ? ID_VALUE : 32'h00000000;
	end

	default clocking cb @(posedge pclk);
	endclocking
	default disable iff (!presetn);

	a_sweep_no_skip: assert property (
		(st_ff == S_RUN && resp && !last) |=>
		addr_ff == $past(addr_ff) + AW'(1))
		else $error("sweep skipped or repeated an address");
	a_brk_halts: assert property (
		(st_ff == S_RUN && ev && brk_en_ff) |=> st_ff == S_BRK)
		else $error("event with breakpoints did not halt");
	a_brk_each: assert property (
		(st_ff == S_RUN && ev && brk_en_ff) |=> irq_st_ff[0])
		else $error("breakpoint event lost");
	a_nobrk_runs: assert property (
		(st_ff == S_RUN && ev && !brk_en_ff && !last) |=> st_ff == S_RUN)
		else $error("sweep stopped without breakpoints");
	a_first_kept: assert property (
		(!brk_en_ff && ev_seen_ff && !go) |=> $stable(eaddr_ff))
		else $error("first event overwritten");
	a_margin_time: assert property (
		(issue && margin_ff) |=> wait_ff == MARGIN_CYC)
		else $error("margin read not self timed");
	a_ws_time: assert property (
		(issue && !margin_ff) |=> wait_ff == $past(rws_ff) + 4'h1)
		else $error("read not timed by wait states");
	a_req_spacing: assert property (
		issue |-> since_ff > lat)
		else $error("array read issued before its wait states ran out");
	a_brk_holds: assert property (
		(st_ff == S_BRK && !resume) |=> st_ff == S_BRK && !rd_o.req)
		else $error("breakpoint did not hold");
endmodule

// *** src/fai_pkg.sv ***
package fai_pkg;
	localparam logic [11:0] OFF_CTRL = 12'h000;
	localparam logic [11:0] OFF_CFG = 12'h004;
	localparam logic [11:0] OFF_START = 12'h008;
	localparam logic [11:0] OFF_END = 12'h00C;
	localparam logic [11:0] OFF_STAT = 12'h010;
	localparam logic [11:0] OFF_SIG = 12'h014;
	localparam logic [11:0] OFF_EADDR = 12'h018;
	localparam logic [11:0] OFF_IRQ = 12'h01C;
	localparam logic [11:0] OFF_MASK = 12'h020;
	localparam logic [11:0] OFF_ID = 12'h024;
	localparam logic [31:0] ID_VALUE = 32'h0000A5A5;
	localparam logic [31:0] SIG_SEED = 32'hFFFFFFFF;
	localparam logic [31:0] SIG_POLY = 32'h04C11DB7;
	localparam logic [2:0] RWS_RST = 3'h5;
	localparam logic [1:0] APD_RST = 2'h2;
	localparam logic [3:0] MARGIN_CYC = 4'h8;
	localparam int AW = 20;
	typedef enum logic [1:0] {
		FAI_EV_NONE,
		FAI_EV_ECC,
		FAI_EV_SBC
	} fai_ev_t;
	typedef struct packed {
		logic req;
		logic margin;
		logic [AW-1:0] addr;
	} fai_rd_t;
	typedef struct packed {
		logic valid;
		logic ecc_err;
		logic single_bit_correction_event;
		logic [31:0] data;
	} fai_rsp_t;
endpackage

// *** tb/fai_flash_model.sv ***
`timescale 1ns/100ps
module fai_flash_model
	import fai_pkg::*;
(
	input wire logic pclk,
	input wire logic presetn,
	input wire fai_rd_t rd,
	input wire logic [3:0] lat,
	input wire logic [AW-1:0] bad,
	output fai_rsp_t rsp
);
	logic [3:0] cnt_ff;
	logic [AW-1:0] a_ff;
	// answers lat cycles after a request; idle data toggles
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			cnt_ff <= '0;
			a_ff <= '0;
			rsp <= '0;
		end else begin
			rsp <= '{1'b0, 1'b0, 1'b0, ~rsp.data};
			if (rd.req) begin
				cnt_ff <= lat;
				a_ff <= rd.addr;
			end else if (cnt_ff != 4'h0) begin
				cnt_ff <= cnt_ff - 4'h1;
			end
			if (!rd.req && cnt_ff == 4'h1) begin
				rsp <= '{1'b1, a_ff == bad, a_ff == bad + 1, {~a_ff[11:0], a_ff}};
			end
		end
	end
endmodule

// *** tb/fai_checker_bench.sv ***
`timescale 1ns/100ps
module fai_checker_bench;
	import fai_pkg::*;
	logic pclk, presetn, psel, penable, pwrite, pready, pslverr, irq, se;
	logic clr_gap, mg;
	logic [11:0] paddr;
	logic [31:0] pwdata, prdata, q;
	logic [3:0] lat;
	fai_rd_t rd;
	fai_rsp_t rsp;
	int error_cnt, check_count, gap, min_gap;
	fai_checker dut(.pclk(pclk), .presetn(presetn), .psel(psel),
		.penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata),
		.prdata(prdata), .pready(pready), .pslverr(pslverr), .rd_o(rd),
		.rsp_i(rsp), .irq(irq));
	fai_flash_model fm(.pclk(pclk), .presetn(presetn), .rd(rd), .lat(lat),
		.bad(20'h00012), .rsp(rsp));
	initial begin
		pclk = 0;
		forever #2.5 pclk = ~pclk;
	end
	always @(posedge pclk) begin
		gap <= rd.req ? 0 : gap + 1;
		if (clr_gap)
			min_gap <= 99;
		else if (rd.req && gap + 1 < min_gap)
			min_gap <= gap + 1;
		if (rd.req)
			mg <= rd.margin;
	end
	task automatic chk(input logic [31:0] g, e);
		check_count++;
		if (g !== e) begin
			error_cnt++;
			$display("BAD t=%0t got %h exp %h", $time, g, e);
		end
	endtask
	task automatic apb(input logic w, input logic [11:0] a,
		input logic [31:0] d);
		psel <= 1;
		pwrite <= w;
		paddr <= a;
		pwdata <= d;
		@(posedge pclk);
		penable <= 1;
		do begin
			@(posedge pclk);
		end while (pready !== 1'b1);
		q = prdata;
		se = pslverr;
		psel <= 0;
		penable <= 0;
		@(posedge pclk);
	endtask
	task automatic poll(input int b);
		int n;
		n = 0;
		do begin
			apb(0, OFF_STAT, 0);
			n++;
		end while (q[b] !== 1'b1 && n < 200);
		chk(q[b], 1);
	endtask
	function automatic logic [31:0] sig(input logic [19:0] lo, hi);
		logic [31:0] s;
		s = SIG_SEED;
		for (logic [19:0] a = lo; a <= hi; a++)
			s = {s[30:0], 1'b0} ^ (s[31] ? SIG_POLY : 32'h0) ^ {~a[11:0], a};
		return s;
	endfunction
	task automatic run(input logic [2:0] w, input logic [1:0] p,
		input logic b, m, ie);
		clr_gap <= 1;
		apb(1, OFF_CFG, {22'h0, m, b, 2'h0, p, 1'b0, w});
		clr_gap <= 0;
		apb(1, OFF_CTRL, 1);
		for (int k = 0; b && k < 2; k++) begin
			poll(1);
			apb(0, OFF_EADDR, 0);
			chk(q, 18 + k);
			apb(0, OFF_STAT, 0);
			chk(q[5:4], k + 1);
			chk(irq, 1);
			apb(1, OFF_CTRL, 2);
		end
		poll(2);
		apb(0, OFF_SIG, 0);
		chk(q, sig(16, 23));
		chk(min_gap >= (m ? 8 : w + 1), 1);
		chk(mg, m);
		chk(irq, ie);
		apb(0, OFF_IRQ, 0);
		chk(q[1], 1);
		apb(0, OFF_IRQ, 0);
		chk(q, 0);
		if (!b) begin
			apb(0, OFF_STAT, 0);
			chk(q[5:3], 3'h3);
			apb(0, OFF_EADDR, 0);
			chk(q, 18);
		end
	endtask
	task automatic end_of_test;
		if (error_cnt == 0 && check_count > 0) $display("SIMULATION PASSED");
		else $display("SIMULATION FAILED");
		$finish;
	endtask
	initial begin
		{presetn, psel, penable, pwrite, paddr, pwdata, clr_gap} = '0;
		lat = 1;
		repeat (20) @(posedge pclk);
		presetn <= 1;
		@(posedge pclk);
		apb(0, OFF_CFG, 0);
		chk(q, 32'h25);
		apb(0, OFF_ID, 0);
		chk(q, ID_VALUE);
		apb(0, 12'h0FC, 0);
		chk({q, se}, 33'h1);
		apb(1, OFF_START, 16);
		apb(1, OFF_END, 23);
		apb(1, OFF_MASK, 7);
		run(1, 1, 1, 0, 1);
		lat <= 4;
		run(3, 2, 1, 0, 1);
		lat <= 2;
		run(5, 3, 1, 0, 1);
		run(5, 2, 1, 0, 1);
		run(0, 0, 1, 0, 1);
		apb(1, OFF_MASK, 0);
		run(5, 3, 0, 0, 0);
		run(2, 1, 0, 1, 0);
		end_of_test;
	end
	initial begin
		#60000;
		error_cnt++;
		end_of_test;
	end
endmodule
